//--- wvb_cmd_decoder.sv
// Write-and-verify and write-buffer command decoder with APB registers
`timescale 1ns/10ps
`include "wvb_defines.svh"
module wvb_cmd_decoder
  import wvb_pkg::*;
(
  input wire logic clk_i, // 25 MHz clock
  input wire logic rst_i, // Sync reset, high
  input wire apb_req_s apb_i, // APB request
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error
  input wire logic dout_valid_i, // Payload byte valid
  input wire logic [7:0] dout_data_i, // Payload byte
  output logic dout_ready_o, // Payload byte taken
  output med_req_s med_o, // Medium request
  input wire logic med_done_i, // Medium step done
  input wire logic med_ecc_err_i, // Verify decoder error
  input wire logic med_miscmp_i, // Verify miscompare
  input wire logic pi_valid_i, // Block protection info
  input wire logic [31:0] pi_ref_i, // Block reference tag
  input wire logic [15:0] pi_app_i, // Block application tag
  output logic buf_we_o, // Buffer byte write
  output logic [5:0] buf_addr_o, // Buffer byte address
  output logic [7:0] buf_data_o // Buffer byte data
);
  st_s s;
  st_s next_s;

  function automatic logic [31:0] be32(input logic [31:0][7:0] c,
                                       input int i);
    return {c[i], c[i+1], c[i+2], c[i+3]};
  endfunction

  function automatic logic mode_ok(input logic [4:0] m);
    case (m)
      `WB_M_HDR, `WB_M_DATA, `WB_M_DL, `WB_M_DLS, `WB_M_DLOS,
      `WB_M_ECHO, `WB_M_DLSEL, `WB_M_DLDEF, `WB_M_ACT,
      `WB_M_EXP: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Descriptor fields
  // ----------------------------------------------------------------
  logic [7:0] op;
  logic is_wv;
  logic is_v32;
  logic [4:0] wb_mode;
  logic [7:0] wb_id;
  logic [23:0] wb_off;
  logic [23:0] wb_len;
  logic dec;
  logic prot_ok;
  logic [31:0] wv_len;
  assign op = s.cdb[0];
  assign is_v32 = (op == `OP_VAR32) &&
                  ({s.cdb[8], s.cdb[9]} == `SA_WV32) &&
                  (s.cdb[7] == `ADDL_LEN32);
  assign is_wv = (op == `OP_WV12) || (op == `OP_WV16) || is_v32;
  assign wb_mode = s.cdb[1][4:0];
  assign wb_id = s.cdb[2];
  assign wb_off = {s.cdb[3], s.cdb[4], s.cdb[5]};
  assign wb_len = {s.cdb[6], s.cdb[7], s.cdb[8]};
  assign dec = (s.state == S_DECODE);
  assign prot_ok = s.prot_on && (s.ptype == `PTYPE_T2);
  always_comb begin
    wv_len = be32(s.cdb, 28);
    if (op == `OP_WV12) begin
      wv_len = be32(s.cdb, 6);
    end else if (op == `OP_WV16) begin
      wv_len = be32(s.cdb, 10);
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic fail;
    logic ok;
    logic [3:0] fkey;
    logic [7:0] fasc;
    logic [7:0] fl;
    logic pe;
    logic [4:0] bi;
    fail = 1'b0;
    ok = 1'b0;
    fkey = 4'h0;
    fasc = 8'h00;
    fl = 8'h00;
    pe = s.pi_err;
    bi = 5'h00;
    next_s = s;
    next_s.start = 1'b0;
    next_s.med.write = 1'b0;
    next_s.med.verify = 1'b0;
    next_s.med.seek = 1'b0;
    next_s.med.flush = 1'b0;
    next_s.buf_we = 1'b0;
    // APB read data is latched in the setup cycle, so access is 0 wait
    if (apb_i.psel && !apb_i.penable) begin
      next_s.rdata = 32'h0000_0000;
      next_s.rerr = 1'b0;
      if (apb_i.paddr[1:0] != 2'h0) begin
        next_s.rerr = 1'b1;
      end else if (apb_i.paddr < `A_CTRL) begin
        bi = {apb_i.paddr[4:2], 2'h0};
        next_s.rdata = {s.cdb[bi + 5'h3], s.cdb[bi + 5'h2],
                        s.cdb[bi + 5'h1], s.cdb[bi]};
      end else if (apb_i.paddr == `A_CTRL) begin
        next_s.rdata[`C_PROT] = s.prot_on;
        next_s.rdata[`C_PTYPE +: 3] = s.ptype;
        next_s.rdata[`C_OWNER] = s.app_tag_owner;
        next_s.rdata[`C_CACHE] = s.cache_en;
      end else if (apb_i.paddr == `A_STAT) begin
        next_s.rdata[`F_BUSY] = s.busy;
        next_s.rdata[`F_DONE] = s.done;
        next_s.rdata[`F_CHK] = s.chk;
        next_s.rdata[`F_SKEY +: 4] = s.skey;
        next_s.rdata[`F_ASC +: 8] = s.asc;
      end else if (apb_i.paddr == `A_XFER) begin
        next_s.rdata = {8'h00, s.xfer};
      end else begin
        next_s.rerr = 1'b1;
      end
    end
    // Config and descriptor are frozen while a command runs
    if (apb_i.psel && apb_i.penable && apb_i.pwrite && !s.busy &&
        !s.start && apb_i.paddr[1:0] == 2'h0) begin
      if (apb_i.paddr < `A_CTRL) begin
        bi = {apb_i.paddr[4:2], 2'h0};
        next_s.cdb[bi] = apb_i.pwdata[7:0];
        next_s.cdb[bi + 5'h1] = apb_i.pwdata[15:8];
        next_s.cdb[bi + 5'h2] = apb_i.pwdata[23:16];
        next_s.cdb[bi + 5'h3] = apb_i.pwdata[31:24];
      end else if (apb_i.paddr == `A_CTRL) begin
        next_s.start = apb_i.pwdata[`C_START];
        next_s.prot_on = apb_i.pwdata[`C_PROT];
        next_s.ptype = apb_i.pwdata[`C_PTYPE +: 3];
        next_s.app_tag_owner = apb_i.pwdata[`C_OWNER];
        next_s.cache_en = apb_i.pwdata[`C_CACHE];
      end
    end
    case (s.state)
      S_IDLE: begin
        if (s.start) begin
          next_s.busy = 1'b1;
          next_s.done = 1'b0;
          next_s.chk = 1'b0;
          next_s.skey = 4'h0;
          next_s.asc = 8'h00;
          next_s.xfer = 24'h000000;
          next_s.state = S_DECODE;
        end
      end
      S_DECODE: begin
        // Reserved bits are never inspected; and
        if (is_wv) begin
          next_s.is32 = is_v32;
          fl = is_v32 ? s.cdb[10] : s.cdb[1];
          next_s.med.prot_sel = fl[7:5];
          next_s.med.low_prio = fl[4];
          next_s.med.byte_cmp = fl[1];
          next_s.med.fua = s.cache_en;
          next_s.med.len = wv_len;
          next_s.med.lba = {32'h0000_0000, be32(s.cdb, 2)};
          if (op == `OP_WV16) begin
            next_s.med.lba = {be32(s.cdb, 2), be32(s.cdb, 6)};
          end else if (is_v32) begin
            next_s.med.lba = {be32(s.cdb, 12), be32(s.cdb, 16)};
          end
          next_s.reftag = be32(s.cdb, 20);
          next_s.apptag = {s.cdb[24], s.cdb[25]};
          next_s.mask = {s.cdb[26], s.cdb[27]};
          next_s.pi_first = 1'b1;
          next_s.pi_err = 1'b0;
          if (is_v32 && !prot_ok) begin
            fail = 1'b1;
            fkey = `SK_ILLEGAL;
            fasc = `ASC_BAD_OP;
          end else if (wv_len == 32'h0000_0000) begin
            next_s.med.seek = 1'b1;
            ok = 1'b1;
          end else if (s.cache_en) begin
            next_s.med.flush = 1'b1;
            next_s.state = S_SYNC;
          end else begin
            next_s.med.write = 1'b1;
            next_s.state = S_WRITE;
          end
        end else if (op == `OP_WBUF) begin
          next_s.med.flush = 1'b1;
          if (!mode_ok(wb_mode)) begin
            fail = 1'b1;
            fkey = `SK_ILLEGAL;
            fasc = `ASC_BAD_FLD;
          end else if (wb_mode != `WB_M_HDR) begin
            ok = 1'b1;
          end else if (wb_id != 8'h00 || wb_off != 24'h000000) begin
            fail = 1'b1;
            fkey = `SK_ILLEGAL;
            fasc = `ASC_BAD_FLD;
          end else if (wb_len > `BUF_CAP) begin
            fail = 1'b1;
            fkey = `SK_ILLEGAL;
            fasc = `ASC_BAD_FLD;
          end else if (wb_len < `WB_HDR_BYTES) begin
            ok = 1'b1;
          end else begin
            next_s.plen = wb_len;
            next_s.cnt = 24'h000000;
            next_s.state = S_BUF;
          end
        end else begin
          fail = 1'b1;
          fkey = `SK_ILLEGAL;
          fasc = `ASC_BAD_OP;
        end
      end
      S_SYNC: begin
        if (med_done_i) begin
          next_s.med.write = 1'b1;
          next_s.state = S_WRITE;
        end
      end
      S_WRITE: begin
        if (pi_valid_i && s.is32) begin
          next_s.pi_first = 1'b0;
          if (s.pi_first && pi_ref_i != s.reftag) begin
            pe = 1'b1;
          end
          if (s.app_tag_owner &&
              ((pi_app_i ^ s.apptag) & s.mask) != 16'h0000) begin
            pe = 1'b1;
          end
          next_s.pi_err = pe;
        end
        if (med_done_i) begin
          if (pe) begin
            fail = 1'b1;
            fkey = `SK_ABORT;
            fasc = `ASC_PI;
          end else begin
            next_s.med.verify = 1'b1;
            next_s.state = S_VERIFY;
          end
        end
      end
      S_VERIFY: begin
        if (med_done_i) begin
          if (med_ecc_err_i && !s.med.byte_cmp) begin
            fail = 1'b1;
            fkey = `SK_MEDIUM;
            fasc = `ASC_ECC;
          end else if (med_miscmp_i && s.med.byte_cmp) begin
            fail = 1'b1;
            fkey = `SK_MISCMP;
            fasc = `ASC_MISCMP;
          end else begin
            ok = 1'b1;
          end
        end
      end
      S_BUF: begin
        if (dout_valid_i) begin
          next_s.cnt = s.cnt + 24'h000001;
          if (s.cnt >= `WB_HDR_BYTES) begin
            next_s.buf_we = 1'b1;
            next_s.buf_addr = 6'(s.cnt - `WB_HDR_BYTES);
            next_s.buf_data = dout_data_i;
            next_s.xfer = s.xfer + 24'h000001;
          end
          if (next_s.cnt == s.plen) begin
            ok = 1'b1;
          end
        end
      end
      default: next_s.state = S_IDLE;
    endcase
    if (fail || ok) begin
      next_s.chk = fail;
      next_s.skey = fkey;
      next_s.asc = fasc;
      next_s.busy = 1'b0;
      next_s.done = 1'b1;
      next_s.state = S_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata_o = s.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = apb_i.psel && apb_i.penable && s.rerr;
  assign dout_ready_o = (s.state == S_BUF);
  assign med_o = s.med;
  assign buf_we_o = s.buf_we;
  assign buf_addr_o = s.buf_addr;
  assign buf_data_o = s.buf_data;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_buf_no_medium: assert property (
    s.state == S_BUF |-> !med_o.write && !med_o.verify)
    else $error("medium touched by buffer command");
  chk_buf_flush: assert property (
    dec && op == `OP_WBUF |=> med_o.flush && !med_o.write)
    else $error("buffer command did not flush cache");
  chk_bad_mode: assert property (
    dec && op == `OP_WBUF && !mode_ok(wb_mode) |=>
    s.chk && s.skey == `SK_ILLEGAL && s.asc == `ASC_BAD_FLD)
    else $error("unsupported mode not rejected");
  chk_hdr_id: assert property (
    dec && op == `OP_WBUF && wb_mode == `WB_M_HDR && wb_id != 8'h00
    |=> s.chk && s.state == S_IDLE && s.asc == `ASC_BAD_FLD)
    else $error("nonzero buffer id accepted");
  chk_hdr_strip: assert property (
    s.state == S_BUF && dout_valid_i && s.cnt < `WB_HDR_BYTES
    |=> !buf_we_o)
    else $error("header byte stored");
  chk_store_addr: assert property (
    buf_we_o |-> buf_addr_o == 6'($past(s.cnt) - `WB_HDR_BYTES))
    else $error("stored byte at wrong address");
  chk_short_len: assert property (
    dec && op == `OP_WBUF && wb_mode == `WB_M_HDR && wb_id == 8'h00 &&
    wb_off == 24'h0 && wb_len < `WB_HDR_BYTES |=> s.done && !s.chk)
    else $error("short length not treated as no data");
  chk_prot_type: assert property (
    dec && is_v32 && !prot_ok |=>
    s.chk && s.asc == `ASC_BAD_OP && !med_o.write)
    else $error("32-byte command ran without type 2");
  chk_verify_order: assert property (
    med_o.verify |-> $past(s.state) == S_WRITE && $past(med_done_i))
    else $error("verify not preceded by write");
  chk_zero_seek: assert property (
    dec && is_wv && wv_len == 32'h0 && (!is_v32 || prot_ok) |=>
    med_o.seek && !s.chk && s.done)
    else $error("zero length did not seek");
  chk_sync_first: assert property (
    dec && is_wv && !is_v32 && wv_len != 32'h0 && s.cache_en |=>
    med_o.flush && !med_o.write)
    else $error("write issued before cache sync");
endmodule

//--- wvb_defines.svh
// Offsets, field positions, codes and limits for the command decoder
`ifndef WVB_DEFINES_SVH
`define WVB_DEFINES_SVH
// ----------------------------------------------------------------
// Opcodes and descriptor constants
// ----------------------------------------------------------------
`define OP_WV12 8'hAE
`define OP_WV16 8'h8E
`define OP_VAR32 8'h7F
`define SA_WV32 16'h000C
`define ADDL_LEN32 8'h18
`define OP_WBUF 8'h3B
`define PTYPE_T2 3'h1
// ----------------------------------------------------------------
// Buffer modes, header size and buffer limits
// ----------------------------------------------------------------
`define WB_M_HDR 5'h00
`define WB_M_DATA 5'h02
`define WB_M_DL 5'h04
`define WB_M_DLS 5'h05
`define WB_M_DLOS 5'h07
`define WB_M_ECHO 5'h0A
`define WB_M_DLSEL 5'h0D
`define WB_M_DLDEF 5'h0E
`define WB_M_ACT 5'h0F
`define WB_M_EXP 5'h1A
`define WB_HDR_BYTES 24'h000004
`define BUF_CAP 24'h000040
`define BUF_AW 6
// ----------------------------------------------------------------
// Sense keys and additional sense codes
// ----------------------------------------------------------------
`define SK_ILLEGAL 4'h5
`define SK_MEDIUM 4'h3
`define SK_MISCMP 4'hE
`define SK_ABORT 4'hB
`define ASC_BAD_OP 8'h20
`define ASC_BAD_FLD 8'h24
`define ASC_ECC 8'h11
`define ASC_MISCMP 8'h1D
`define ASC_PI 8'h10
// ----------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------
`define A_CTRL 8'h20
`define A_STAT 8'h24
`define A_XFER 8'h28
`define C_START 0
`define C_PROT 1
`define C_PTYPE 2
`define C_OWNER 5
`define C_CACHE 6
`define F_BUSY 0
`define F_DONE 1
`define F_CHK 2
`define F_SKEY 8
`define F_ASC 16
`endif

//--- wvb_pkg.sv
// Types shared by the command decoder
package wvb_pkg;
  typedef enum logic [2:0] {
    S_IDLE, S_DECODE, S_SYNC, S_WRITE, S_VERIFY, S_BUF
  } state_e;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
  typedef struct packed {
    logic write;
    logic verify;
    logic seek;
    logic flush;
    logic fua;
    logic byte_cmp;
    logic low_prio;
    logic [2:0] prot_sel;
    logic [63:0] lba;
    logic [31:0] len;
  } med_req_s;
  typedef struct packed {
    state_e state;
    logic [31:0][7:0] cdb;
    logic start;
    logic prot_on;
    logic [2:0] ptype;
    logic app_tag_owner;
    logic cache_en;
    logic busy;
    logic done;
    logic chk;
    logic [3:0] skey;
    logic [7:0] asc;
    logic [31:0] rdata;
    logic rerr;
    logic [23:0] plen;
    logic [23:0] cnt;
    logic [23:0] xfer;
    med_req_s med;
    logic is32;
    logic [31:0] reftag;
    logic [15:0] apptag;
    logic [15:0] mask;
    logic pi_first;
    logic pi_err;
    logic buf_we;
    logic [5:0] buf_addr;
    logic [7:0] buf_data;
  } st_s;
endpackage

//--- wvb_medium_model.sv
// Behavioural medium with protection-info source behind the decoder
`timescale 1ns/10ps
module wvb_medium_model
  import wvb_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset, high
  input wire med_req_s med_i, // Medium request
  input wire logic [7:0] dly_i, // Extra answer delay
  input wire logic ecc_i, // Report decoder error
  input wire logic mis_i, // Report miscompare
  input wire logic [31:0] ref_i, // First block reference tag
  input wire logic [15:0] app_i, // Block application tag
  output logic done_o, // Step done
  output logic ecc_err_o, // Decoder error
  output logic miscmp_o, // Miscompare
  output logic pi_valid_o, // Protection info valid
  output logic [31:0] pi_ref_o, // Reference tag
  output logic [15:0] pi_app_o // Application tag
);
  logic [8:0] wait_n;
  logic [31:0] blk;
  logic in_wr;
  logic in_vf;
  logic pv;
  logic last;
  // Protection info for the first few blocks of a write, one per cycle
  assign pv = (wait_n != 9'h000) && in_wr && blk < med_i.len &&
              blk < 32'h8;
  assign last = (wait_n == 9'h001);
  always @(posedge clk_i) begin
    if (rst_i) begin
      wait_n <= '0;
      blk <= '0;
      in_wr <= 1'b0;
      in_vf <= 1'b0;
      done_o <= 1'b0;
      pi_valid_o <= 1'b0;
      ecc_err_o <= 1'b0;
      miscmp_o <= 1'b0;
      pi_ref_o <= '0;
      pi_app_o <= '0;
    end else begin
      done_o <= last;
      pi_valid_o <= pv;
      // Lines toggle between answers so nothing stale reads as valid
      ecc_err_o <= last ? (in_vf & ecc_i) : ~ecc_err_o;
      miscmp_o <= last ? (in_vf & mis_i) : ~miscmp_o;
      pi_ref_o <= pv ? ref_i + blk : ~pi_ref_o;
      pi_app_o <= pv ? app_i : ~pi_app_o;
      if (wait_n != 9'h000) begin
        wait_n <= wait_n - 9'h001;
        if (pv) begin
          blk <= blk + 32'h1;
        end
      end else if (med_i.flush || med_i.write || med_i.verify) begin
        wait_n <= {1'b0, dly_i} + 9'h00A;
        in_wr <= med_i.write;
        in_vf <= med_i.verify;
        blk <= '0;
      end
    end
  end
endmodule

//--- write_verify_and_buffer_cmd_decoder_tb.sv
// Self-checking bench for the command decoder
`timescale 1ns/10ps
`include "wvb_defines.svh"
module write_verify_and_buffer_cmd_decoder_tb;
  import wvb_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  apb_req_s apb = '0;
  logic [31:0] prdata_o, pi_ref_i, m_ref = '0;
  logic pready_o, pslverr_o, dout_ready_o, buf_we_o, pi_valid_i;
  logic med_done_i, med_ecc_err_i, med_miscmp_i;
  logic dout_valid_i = 1'b0, m_ecc = 1'b0, m_mis = 1'b0;
  logic [7:0] dout_data_i = 8'hFF, m_dly = 8'h00, buf_data_o;
  logic [15:0] pi_app_i, m_app = '0, trace = '0;
  logic [5:0] buf_addr_o;
  med_req_s med_o;
  logic [7:0] cdb [32];
  int n_errors = 0, samples_checked = 0, cycles = 0;
  int pay_n = 0, pay_i = 0, pay_b = 0, n_buf = 0;

  wvb_cmd_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .apb_i(apb),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .dout_valid_i(dout_valid_i), .dout_data_i(dout_data_i),
    .dout_ready_o(dout_ready_o), .med_o(med_o), .med_done_i(med_done_i),
    .med_ecc_err_i(med_ecc_err_i), .med_miscmp_i(med_miscmp_i),
    .pi_valid_i(pi_valid_i), .pi_ref_i(pi_ref_i), .pi_app_i(pi_app_i),
    .buf_we_o(buf_we_o), .buf_addr_o(buf_addr_o), .buf_data_o(buf_data_o));
  wvb_medium_model med (.clk_i(clk_i), .rst_i(rst_i), .med_i(med_o),
    .dly_i(m_dly), .ecc_i(m_ecc), .mis_i(m_mis), .ref_i(m_ref),
    .app_i(m_app), .done_o(med_done_i), .ecc_err_o(med_ecc_err_i),
    .miscmp_o(med_miscmp_i), .pi_valid_o(pi_valid_i),
    .pi_ref_o(pi_ref_i), .pi_app_o(pi_app_i));

  initial forever #20 clk_i = ~clk_i;

  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      finish_test();
    end
  end

  // Host payload source; a byte offered is held until taken
  always @(posedge clk_i) begin : host
    int k;
    k = pay_i + ((dout_valid_i && dout_ready_o) ? 1 : 0);
    pay_i <= k;
    if (!(dout_valid_i && !dout_ready_o)) begin
      dout_valid_i <= (k < pay_n) && (cycles % 3 != 0);
      if (k < pay_n)
        dout_data_i <= (k - pay_b < 4) ? 8'h5A : 8'(8'hA0 + k - pay_b);
      else
        dout_data_i <= ~dout_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (buf_we_o) begin
      check({24'h0, buf_data_o}, {24'h0, 8'hA4 + 8'(buf_addr_o)});
      n_buf++;
    end
    if (med_o.flush) trace = {trace[11:0], 4'h1};
    if (med_o.write) trace = {trace[11:0], 4'h2};
    if (med_o.verify) trace = {trace[11:0], 4'h3};
    if (med_o.seek) trace = {trace[11:0], 4'h4};
  end

  task automatic apb_xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic er);
    @(posedge clk_i);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk_i);
    apb.penable <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    rd = prdata_o;
    er = pslverr_o;
    apb <= '0;
  endtask

  task automatic apb_write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb_xfer(1'b1, a, d, r, e);
  endtask

  task automatic apb_read(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb_xfer(1'b0, a, '0, r, e);
  endtask

  // Load descriptor, start, poll until done, compare status
  task automatic run(input logic [31:0] ctl, input logic [3:0] sk,
      input logic [7:0] asc);
    logic [31:0] r;
    for (int i = 0; i < 8; i++)
      apb_write(8'(4 * i), {cdb[4*i+3], cdb[4*i+2], cdb[4*i+1], cdb[4*i]});
    trace = '0;
    n_buf = 0;
    apb_write(`A_CTRL, ctl | 32'h1);
    r = 32'h1;
    for (int t = 0; t < 500 && r[1:0] !== 2'b10; t++) apb_read(`A_STAT, r);
    check(r, {8'h00, asc, 4'h0, sk, 5'h00, sk != 4'h0, 2'b10});
  endtask

  task automatic cdb_clr();
    foreach (cdb[i]) cdb[i] = 8'h00;
  endtask

  logic [31:0] t_ctl [6] = '{32'h0A, 32'h06, 32'h26, 32'h26, 32'h06, 32'h04};
  logic [15:0] t_msk [6] = '{16'hFFFF, 16'hFFFF, 16'h000F, 16'hFFFF,
    16'hFFFF, 16'hFFFF};
  logic [11:0] t_se [6] = '{12'h520, 12'h000, 12'h000, 12'hB10, 12'hB10,
    12'h520};
  logic [4:0] t_md [12] = '{5'h00, 5'h02, 5'h04, 5'h05, 5'h07, 5'h0A,
    5'h0D, 5'h0E, 5'h0F, 5'h1A, 5'h01, 5'h1F};
  logic [7:0] b_id [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  logic [7:0] b_of [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  logic [7:0] b_ln [6] = '{8'h06, 8'h40, 8'h41, 8'h06, 8'h06, 8'h03};

  initial begin
    logic [31:0] r;
    logic e;
    logic ok;
    int nb;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    apb_read(`A_CTRL, r);
    check(r, 32'h0);
    apb_read(`A_STAT, r);
    check(r, 32'h0);
    apb_read(`A_XFER, r);
    check(r, 32'h0);
    apb_xfer(1'b0, 8'h40, '0, r, e);
    check({31'h0, e}, 32'h1);
    apb_xfer(1'b1, 8'h21, 32'hFF, r, e);
    check({31'h0, e}, 32'h1);
    apb_write(`A_CTRL, 32'h7E);
    apb_read(`A_CTRL, r);
    check(r, 32'h7E);
    // 12-byte: flags, address and length fields, miscompare
    cdb_clr();
    cdb[0] = `OP_WV12;
    cdb[1] = 8'hB2;
    {cdb[2], cdb[3], cdb[4], cdb[5]} = 32'h01020304;
    cdb[9] = 8'h02;
    m_mis <= 1'b1;
    run(32'h0, `SK_MISCMP, `ASC_MISCMP);
    check({16'h0, trace}, 32'h23);
    check(med_o.lba[31:0], 32'h01020304);
    check(med_o.len, 32'h2);
    check({med_o.byte_cmp, med_o.low_prio, med_o.prot_sel}, 32'h1D);
    m_mis <= 1'b0;
    cdb[9] = 8'h00;
    run(32'h0, 4'h0, 8'h00);
    check({16'h0, trace}, 32'h4);
    // 16-byte with cache on, slow medium
    cdb_clr();
    cdb[0] = `OP_WV16;
    for (int i = 2; i < 10; i++) cdb[i] = 8'(8'h0F + i);
    cdb[13] = 8'h03;
    m_ecc <= 1'b1;
    m_dly <= 8'hC8;
    run(32'h40, `SK_MEDIUM, `ASC_ECC);
    check({16'h0, trace}, 32'h123);
    check({31'h0, med_o.fua}, 32'h1);
    check(med_o.lba[63:32], 32'h11121314);
    check(med_o.len, 32'h3);
    cdb[1] = 8'h02;
    run(32'h40, 4'h0, 8'h00);
    check({16'h0, trace}, 32'h123);
    m_ecc <= 1'b0;
    m_dly <= 8'h00;
    // 32-byte: protection type, reference and application tags
    cdb_clr();
    cdb[0] = `OP_VAR32;
    cdb[7] = `ADDL_LEN32;
    cdb[9] = 8'h0C;
    cdb[22] = 8'h10;
    cdb[25] = 8'hF0;
    cdb[31] = 8'h02;
    for (int i = 0; i < 6; i++) begin
      {cdb[26], cdb[27]} = t_msk[i];
      m_ref <= (i == 4) ? 32'h1001 : 32'h1000;
      run(t_ctl[i], t_se[i][11:8], t_se[i][7:0]);
    end
    check({16'h0, trace}, 32'h0);
    // Other service action under the same opcode is not this command
    cdb[9] = 8'h0B;
    run(32'h06, `SK_ILLEGAL, `ASC_BAD_OP);
    check({16'h0, trace}, 32'h0);
    // Buffer modes, none with payload
    cdb_clr();
    cdb[0] = `OP_WBUF;
    for (int i = 0; i < 12; i++) begin
      cdb[1] = {3'h0, t_md[i]};
      run(32'h0, (i < 10) ? 4'h0 : `SK_ILLEGAL,
          (i < 10) ? 8'h00 : `ASC_BAD_FLD);
      check({16'h0, trace}, 32'h1);
    end
    // Header mode: id, offset, length limits and header stripping
    cdb[1] = 8'h00;
    for (int i = 0; i < 6; i++) begin
      cdb[2] = b_id[i];
      cdb[5] = b_of[i];
      cdb[8] = b_ln[i];
      ok = b_id[i] == 8'h00 && b_of[i] == 8'h00 && b_ln[i] <= 8'h40;
      nb = (ok && b_ln[i] >= 8'h04) ? b_ln[i] - 4 : 0;
      pay_b = pay_i;
      pay_n = pay_i + ((nb > 0) ? b_ln[i] : 0);
      run(32'h0, ok ? 4'h0 : `SK_ILLEGAL,
          ok ? 8'h00 : `ASC_BAD_FLD);
      check(n_buf, nb);
      apb_read(`A_XFER, r);
      if (ok) check(r, nb);
    end
    finish_test();
  end
endmodule
